// ===== rtl/pdps_top.v
/*
 * PWM driver protocol selector with an AXI4-Lite register slave, a small
 * PWM generator and the power-up protocol fetch sequence.
 * Assumes synchronous pins, a nonvolatile loader answering on nvm_valid,
 * and an outside wire resolver for the three-state pwm and enable pins.
 */
// The implementer's own choices: the placing of the registers and the AXI4-Lite register port.
`include "pdps_regs.vh"

module pdps_top #(
  parameter FETCH_CYCLES = `PDPS_FETCH_CYC
) (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        ce,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output wire        nvm_req,
  input  wire        nvm_valid,
  input  wire [1:0]  nvm_protocol,
  input  wire        nvm_dcm,
  input  wire        zero_current,
  output reg         pwm_o,
  output reg         pwm_oe,
  input  wire        en_i,
  output reg         en_o,
  output reg         en_oe,
  output reg         en_pulldown
);

  localparam [1:0]  ST_SETTLE = 2'd0;
  localparam [1:0]  ST_FETCH  = 2'd1;
  localparam [1:0]  ST_RUN    = 2'd2;
  localparam integer FETCH_LAST_I  = FETCH_CYCLES - 1;
  localparam integer SETTLE_LAST_I = `PDPS_SETTLE_CYC - 1;
  localparam [23:0]  FETCH_LAST    = FETCH_LAST_I[23:0];
  localparam [23:0]  SETTLE_LAST   = SETTLE_LAST_I[23:0];

  reg  [1:0]  state_q;
  reg  [23:0] timer_q;
  reg         strap_q;
  reg         from_nvm_q;
  reg         timeout_q;
  reg  [3:0]  ctrl_q;
  reg  [15:0] period_q;
  reg  [15:0] duty_q;
  reg  [15:0] cnt_q;
  reg         aw_got_q;
  reg         w_got_q;
  reg  [7:0]  awaddr_q;
  reg  [31:0] wdata_q;
  reg  [3:0]  wstrb_q;
  reg  [31:0] rdata_d;
  reg         rmap_d;
  reg         pwm_d;
  reg         pwm_oe_d;
  reg         en_o_d;
  reg         en_oe_d;
  reg         pd_d;

  wire [1:0] prot    = ctrl_q[`PDPS_CTRL_PROT_HI:`PDPS_CTRL_PROT_LO];
  wire       running = (state_q == ST_RUN);
  wire       wr_go   = aw_got_q && w_got_q && !s_axi_bvalid;
  wire       wr_map  = (awaddr_q[7:2] <= `PDPS_ADDR_STATUS >> 2) &&
                       (awaddr_q[1:0] == 2'b00);
  // Strap high forbids discontinuous conduction, in protocol 0 only.
  wire       dcm_eff = ctrl_q[`PDPS_CTRL_DCM] &&
                       !((prot == 2'h0) && strap_q);

  // Merges the enabled byte lanes of new into old.
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nval;
    input [3:0]  strb;
    integer      i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          merge[i*8 +: 8] = nval[i*8 +: 8];
        end
      end
    end
  endfunction

  assign s_axi_awready = ce && !aw_got_q && !s_axi_bvalid;
  assign s_axi_wready  = ce && !w_got_q && !s_axi_bvalid;
  assign s_axi_arready = ce && !s_axi_rvalid;
  assign nvm_req       = (state_q == ST_FETCH);

  wire [31:0] ctrl_wr   = merge({28'h0, ctrl_q}, wdata_q, wstrb_q);
  wire [31:0] period_wr = merge({16'h0, period_q}, wdata_q, wstrb_q);
  wire [31:0] duty_wr   = merge({16'h0, duty_q}, wdata_q, wstrb_q);

  always @* begin
    rdata_d = 32'h0000_0000;
    rmap_d  = 1'b1;
    case (s_axi_araddr)
      `PDPS_ADDR_CTRL:   rdata_d = {28'h0, ctrl_q};
      `PDPS_ADDR_PERIOD: rdata_d = {16'h0, period_q};
      `PDPS_ADDR_DUTY:   rdata_d = {16'h0, duty_q};
      `PDPS_ADDR_STATUS: rdata_d = {24'h0, timeout_q, from_nvm_q, dcm_eff,
                                    prot, strap_q, state_q};
      default:           rmap_d  = 1'b0;
    endcase
  end

  // Output pin drive per protocol and sequencer state.
  always @* begin
    pwm_d    = 1'b0;
    pwm_oe_d = 1'b0;
    en_o_d   = 1'b0;
    en_oe_d  = 1'b0;
    pd_d     = 1'b1;
    if (running && (prot != 2'h0)) begin
      pd_d    = 1'b0;
      en_oe_d = 1'b1;
      en_o_d  = ctrl_q[`PDPS_CTRL_RUN];
    end
    if (running && ctrl_q[`PDPS_CTRL_RUN]) begin
      pwm_d    = (cnt_q < duty_q);
      pwm_oe_d = 1'b1;
      // Floating the pwm pin in the off phase lets a fast driver emulate
      // a diode; without discontinuous conduction both edges are driven.
      if ((prot == 2'h0) && dcm_eff && !pwm_d && zero_current) begin
        pwm_oe_d = 1'b0;
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      state_q      <= ST_SETTLE;
      timer_q      <= 24'h00_0000;
      strap_q      <= 1'b0;
      from_nvm_q   <= 1'b0;
      timeout_q    <= 1'b0;
      ctrl_q       <= `PDPS_CTRL_RESET;
      period_q     <= `PDPS_PERIOD_RESET;
      duty_q       <= `PDPS_DUTY_RESET;
      cnt_q        <= 16'h0000;
      aw_got_q     <= 1'b0;
      w_got_q      <= 1'b0;
      awaddr_q     <= 8'h00;
      wdata_q      <= 32'h0000_0000;
      wstrb_q      <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `PDPS_RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp  <= `PDPS_RESP_OKAY;
      s_axi_rdata  <= 32'h0000_0000;
      pwm_o        <= 1'b0;
      pwm_oe       <= 1'b0;
      en_o         <= 1'b0;
      en_oe        <= 1'b0;
      en_pulldown  <= 1'b1;
    end else if (ce) begin
      pwm_o       <= pwm_d;
      pwm_oe      <= pwm_oe_d;
      en_o        <= en_o_d;
      en_oe       <= en_oe_d;
      en_pulldown <= pd_d;

      case (state_q)
        ST_SETTLE: begin
          timer_q <= timer_q + 24'h00_0001;
          if (timer_q == SETTLE_LAST) begin
            strap_q <= en_i;
            state_q <= ST_FETCH;
          end
        end
        ST_FETCH: begin
          timer_q <= timer_q + 24'h00_0001;
          if (nvm_valid) begin
            ctrl_q[`PDPS_CTRL_PROT_HI:`PDPS_CTRL_PROT_LO] <= nvm_protocol;
            ctrl_q[`PDPS_CTRL_DCM] <= nvm_dcm;
            from_nvm_q <= 1'b1;
            state_q    <= ST_RUN;
          end else if (timer_q == FETCH_LAST) begin
            timeout_q <= 1'b1;
            state_q   <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (cnt_q >= period_q) begin
            cnt_q <= 16'h0000;
          end else begin
            cnt_q <= cnt_q + 16'h0001;
          end
        end
        default: begin
          state_q <= ST_SETTLE;
        end
      endcase

      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_got_q     <= 1'b0;
        w_got_q      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_map ? `PDPS_RESP_OKAY : `PDPS_RESP_SLVERR;
        case (awaddr_q)
          `PDPS_ADDR_CTRL: begin
            // Software setting is ignored while the stored one is fetched.
            if (running) begin
              ctrl_q <= ctrl_wr[3:0];
            end
          end
          `PDPS_ADDR_PERIOD: begin
            period_q <= period_wr[15:0];
          end
          `PDPS_ADDR_DUTY: begin
            duty_q <= duty_wr[15:0];
          end
          default: begin
            period_q <= period_q;
          end
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end

      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rdata_d;
        s_axi_rresp  <= rmap_d ? `PDPS_RESP_OKAY : `PDPS_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

// ===== rtl/pdps_regs.vh
`ifndef PDPS_REGS_VH
`define PDPS_REGS_VH

/*
 * Register offsets, field positions, reset values and timing counts of
 * the PWM driver protocol selector.
 * Assumes a 250 MHz aclk and byte addresses on the AXI4-Lite bus.
 */

`define PDPS_ADDR_CTRL    8'h00
`define PDPS_ADDR_PERIOD  8'h04
`define PDPS_ADDR_DUTY    8'h08
`define PDPS_ADDR_STATUS  8'h0C

`define PDPS_CTRL_DCM     0
`define PDPS_CTRL_PROT_LO 1
`define PDPS_CTRL_PROT_HI 2
`define PDPS_CTRL_RUN     3

`define PDPS_PROT_DEFAULT 2'h0
`define PDPS_CTRL_RESET   4'h0
`define PDPS_PERIOD_RESET 16'h00F9
`define PDPS_DUTY_RESET   16'h0000

`define PDPS_CLK_MHZ      250
`define PDPS_FETCH_MS     35
`define PDPS_SETTLE_NS    2000
`define PDPS_FETCH_CYC    (`PDPS_FETCH_MS * 1000 * `PDPS_CLK_MHZ)
`define PDPS_SETTLE_CYC   ((`PDPS_SETTLE_NS * `PDPS_CLK_MHZ + 999) / 1000)

`define PDPS_RESP_OKAY    2'h0
`define PDPS_RESP_SLVERR  2'h2

`endif

// ===== tb/pdps_chk_sva.sv
/* Pin and bus checker for the protocol selector.
   Assumes ce is held high and binds to pdps_top. */
module pdps_chk #(
  parameter FETCH_CYCLES = 2000
) (
  input wire aclk,
  input wire aresetn,
  input wire nvm_req,
  input wire nvm_valid,
  input wire pwm_oe,
  input wire en_oe,
  input wire en_pulldown,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] tcnt_q;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  always @(posedge aclk) begin
    if (!aresetn) tcnt_q <= 16'h0000;
    else if (tcnt_q != 16'hFFFF) tcnt_q <= tcnt_q + 16'h0001;
  end
  a_reset_pins: assert property (disable iff (1'b0) !aresetn |=>
    !pwm_oe && !en_oe && en_pulldown) else $error("pins not idle");
  a_settle_quiet: assert property (tcnt_q < 16'h01F4 |->
    !nvm_req && !pwm_oe) else $error("early fetch or pulse");
  a_fetch_bound: assert property (nvm_req |->
    tcnt_q < FETCH_CYCLES) else $error("fetch too long");
  a_fetch_quiet: assert property (nvm_req |->
    !pwm_oe && !en_oe) else $error("pin driven in fetch");
  a_load_ends: assert property (nvm_req && nvm_valid |=>
    !nvm_req) else $error("fetch kept after load");
  a_drive_nopd: assert property (en_oe |->
    !en_pulldown) else $error("pull-down while driving");
  a_read_next: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read answer late");
  a_read_drop: assert property (s_axi_rvalid && s_axi_rready |=>
    !s_axi_rvalid) else $error("read answer kept");
  c_load: cover property (nvm_req && nvm_valid);
  c_timeout: cover property ($fell(nvm_req) && !$past(nvm_valid));
  c_drive: cover property (en_oe && pwm_oe);
endmodule
bind pdps_top pdps_chk #(.FETCH_CYCLES(FETCH_CYCLES)) pdps_chk_i (
  .aclk(aclk), .aresetn(aresetn), .nvm_req(nvm_req),
  .nvm_valid(nvm_valid), .pwm_oe(pwm_oe), .en_oe(en_oe),
  .en_pulldown(en_pulldown), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready));

// ===== tb/pdps_far.sv
/* Far-side model: the stored-setting loader and the enable strap.
   Assumes the bench sets its knobs while the selector is in reset. */
module pdps_far (
  input  wire        aclk,
  input  wire        nvm_req,
  input  wire        en_o,
  input  wire        en_oe,
  input  wire        strap_hi,
  input  wire        mute,
  input  wire [7:0]  delay,
  input  wire [1:0]  prot,
  output logic       nvm_valid,
  output logic [1:0] nvm_protocol,
  output logic       nvm_dcm,
  output wire        en_i
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] wait_q;
  logic       hit;
  initial begin
    wait_q = 8'h00;
    nvm_valid = 1'b0;
    nvm_protocol = 2'h0;
    nvm_dcm = 1'b0;
  end
  // An undriven enable sits on the weak pull-down unless strapped high.
  assign en_i = en_oe ? en_o : strap_hi;
  assign hit = nvm_req && !mute && wait_q == delay;
  always @(posedge aclk) begin
    wait_q <= nvm_req ? wait_q + 8'h01 : 8'h00;
    nvm_valid <= hit;
    nvm_protocol <= hit ? prot : ~nvm_protocol;
    nvm_dcm <= hit ? 1'b1 : ~nvm_dcm;
  end
endmodule

// ===== tb/pdps_top_test.sv
/* Self-checking bench of the protocol selector.
   Assumes a 4 ns clock and a shortened fetch limit. */
module pdps_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        aclk, aresetn, zero_current, strap_hi, mute;
  logic        awv, wv, arv, ta, tw, done;
  logic [7:0]  addr, delay;
  logic [31:0] wdata, got;
  logic [1:0]  prot, p, rsp;
  wire         awready, wready, bvalid, arready, rvalid, nvm_req;
  wire         nvm_valid, nvm_dcm, pwm_o, pwm_oe, en_i, en_o, en_oe, en_pd;
  wire [31:0]  rdata;
  wire [1:0]   bresp, rresp, nvm_protocol;
  integer      bad_count, cmp_count, i, seed;
  pdps_top #(.FETCH_CYCLES(2000)) pdps_top_i (.aclk(aclk),
    .aresetn(aresetn), .ce(1'b1), .s_axi_awaddr(addr),
    .s_axi_awvalid(awv), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
    .s_axi_araddr(addr), .s_axi_arvalid(arv), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(1'b1), .nvm_req(nvm_req), .nvm_valid(nvm_valid),
    .nvm_protocol(nvm_protocol), .nvm_dcm(nvm_dcm),
    .zero_current(zero_current), .pwm_o(pwm_o), .pwm_oe(pwm_oe),
    .en_i(en_i), .en_o(en_o), .en_oe(en_oe), .en_pulldown(en_pd));
  pdps_far pdps_far_i (.aclk(aclk), .nvm_req(nvm_req), .en_o(en_o),
    .en_oe(en_oe), .strap_hi(strap_hi), .mute(mute), .delay(delay),
    .prot(prot), .nvm_valid(nvm_valid), .nvm_protocol(nvm_protocol),
    .nvm_dcm(nvm_dcm), .en_i(en_i));
  function [31:0] exp_st(input s, input [1:0] q, input m);
    exp_st = {24'h0, m, !m, !m && !(q == 2'h0 && s), q, s, 2'h2};
  endfunction
  task chk(input string nm, input [31:0] e, input [31:0] g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task bus(input w, input [7:0] a, input [31:0] d);
    @(posedge aclk);
    addr <= a;
    wdata <= d;
    awv <= w;
    wv <= w;
    arv <= !w;
    done = 1'b0;
    while (!done) begin
      @(negedge aclk);
      ta = w ? awready : arready;
      tw = wready;
      done = w ? bvalid : rvalid;
      got = rdata;
      rsp = w ? bresp : rresp;
      @(posedge aclk);
      if (ta) awv <= 1'b0;
      if (ta) arv <= 1'b0;
      if (tw) wv <= 1'b0;
    end
  endtask
  task stop_test;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  initial begin
    #(4 * 30000);
    bad_count++;
    stop_test;
  end
  initial begin
    {aresetn, zero_current, strap_hi, mute, awv, wv, arv} = 7'h00;
    {addr, delay, wdata, prot} = 50'h0;
    {bad_count, cmp_count, seed} = {32'h0, 32'h0, 32'h82C3A3EA};
    for (i = 0; i < 6; i++) begin
      @(posedge aclk);
      aresetn <= 1'b0;
      strap_hi <= i[2];
      prot <= i[1:0];
      mute <= (i == 5);
      delay <= 8'($random(seed));
      zero_current <= 1'($random(seed));
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      while (!nvm_req) @(posedge aclk);
      while (nvm_req) @(posedge aclk);
      zero_current <= 1'b0;
      p = (i == 5) ? 2'h0 : i[1:0];
      bus(1'b0, 8'h0C, 32'h0);
      chk("status", exp_st(i[2], p, i == 5), got);
      bus(1'b1, 8'h00, {28'h0, 1'b1, p, 1'b1});
      chk("ctrl_bresp", 32'h0, {30'h0, rsp});
      repeat (3) @(posedge aclk);
      @(negedge aclk);
      chk("en_oe", {31'h0, p != 2'h0}, {31'h0, en_oe});
      chk("en_o", {31'h0, p != 2'h0}, {31'h0, en_o});
      chk("en_pd", {31'h0, p == 2'h0}, {31'h0, en_pd});
      chk("pwm_oe", 32'h1, {31'h0, pwm_oe});
      @(posedge aclk);
      zero_current <= 1'b1;
      repeat (3) @(posedge aclk);
      @(negedge aclk);
      chk("pwm_float", {31'h0, p != 0 || i[2]}, {31'h0, pwm_oe});
      $display("test %0d done", i);
    end
    bus(1'b1, 8'h08, 32'h0000FFFF);
    @(negedge aclk);
    chk("pwm_o", 32'h1, {31'h0, pwm_o});
    bus(1'b0, 8'h10, 32'h0);
    chk("unmapped", 32'h2, {30'h0, rsp});
    chk("unmapped_data", 32'h0, got);
    stop_test;
  end
endmodule
